// ### rtl/mbtg_regs.vh
/*
  Constants of the memory bus transaction generator: transfer sizes,
  block geometry and cycle-type codes.
  Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef MBTG_REGS_VH
`define MBTG_REGS_VH

// =====================================================================
// Block geometry
`define MBTG_WORDS_PER_BLOCK 4'h8
`define MBTG_WORD_BYTES      3'h4
`define MBTG_FILL_WORDS      4'h8
`define MBTG_SUBBLOCK_WORDS  4'h4

// =====================================================================
// Request kinds
`define MBTG_KIND_READ   2'h0
`define MBTG_KIND_WRITE  2'h1
`define MBTG_KIND_FILL   2'h2

// =====================================================================
// Configuration codes
`define MBTG_CFG_STANDARD 1'b0
`define MBTG_CFG_ENHANCED 1'b1

// =====================================================================
// Full byte mask of one word
`define MBTG_MASK_FULL 4'hf

`endif

// ### rtl/mbtg_shape_check.v
/*
  Combinational shape check of a requested bus transaction.
  Assumes inputs come from logic on the same clock as the generator.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mbtg_regs.vh"

module mbtg_shape_check (
  input  wire       enhanced,
  input  wire [1:0] kind,
  input  wire [3:0] len,
  input  wire [2:0] start,
  input  wire [31:0] masks,
  output reg        legal
);

  // =====================================================================
  // Start-index legality per burst length
  function start_ok;
    input [3:0] l;
    input [2:0] s;
    begin
      case (l)
        4'h1: start_ok = 1'b1;
        4'h2: start_ok = (s != 3'h3) && (s != 3'h7);
        4'h3: start_ok = (s[1] == 1'b0);
        4'h4: start_ok = (s[1:0] == 2'h0);
        4'h8: start_ok = (s == 3'h0);
        default: start_ok = 1'b0;
      endcase
    end
  endfunction

  integer   i;
  reg       mask_ok;
  reg [3:0] lane;

  // Byte-lane rules depend on configuration and position in the burst
  always @* begin
    mask_ok = 1'b1;
    lane    = 4'h0;
    for (i = 0; i < 8; i = i + 1) begin
      lane = masks[4*i +: 4];
      if (i < len) begin
        if (len == 4'h8 || (!enhanced && len != 4'h1)) begin
          if (lane != `MBTG_MASK_FULL) mask_ok = 1'b0;
        end else if (i == 0 || i == len - 1) begin
          if (lane == 4'h0) mask_ok = 1'b0;
        end
      end
    end
  end

  // Legal shape: reads single or 8-word fill; writes 1,2,3,4,8 per mode
  always @* begin
    legal = 1'b0;
    case (kind)
      `MBTG_KIND_READ: legal = (len == 4'h1);
      `MBTG_KIND_FILL:
        legal = (len == `MBTG_FILL_WORDS) &&
                (enhanced || start == 3'h0);
      `MBTG_KIND_WRITE: begin
        if (enhanced)
          legal = (len == 4'h1 || len == 4'h2 || len == 4'h3 ||
                   len == 4'h4 || len == 4'h8);
        else
          legal = (len == 4'h1 || len == 4'h2 || len == 4'h3 ||
                   len == 4'h4 || len == 4'h8);
        legal = legal && start_ok(len, start) && mask_ok;
      end
      default: legal = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ### rtl/mbtg_beat_addr.v
/*
  Beat address former: block base plus wrapped or linear word index.
  Assumes word index and base are held by the caller.
*/
`timescale 1ns/100ps
`default_nettype none

module mbtg_beat_addr (
  input  wire [31:0] base,
  input  wire [2:0]  first,
  input  wire [2:0]  step,
  output wire [31:0] addr
);

  // Wraps inside the aligned block, so no beat leaves it
  wire [2:0] idx;
  assign idx  = first + step;
  assign addr = {base[31:5], idx, 2'b00};

endmodule
`default_nettype wire

// ### rtl/mbtg_gen.v
/*
  Memory bus transaction generator. Takes one request at a time
  (single read, cache line fill, single or burst write with per-word
  byte masks) and drives it onto the external bus as an idle cycle and
  a run of sequential beats.
  Assumes the request comes from on-chip logic on sys_clk, the memory
  clock, and that the memory side keeps up without wait states here;
  wait stalling is handled by neighbouring logic.
  One transfer runs as follows: the request is taken at an edge; the
  next cycle is the idle cycle, with address, line-burst flag and
  direction already posted; then comes one sequential cycle per word,
  then an idle cycle and a one-cycle done pulse, and req_ready returns a cycle later.
  A refused request gets a one-cycle reject pulse and leaves the bus
  untouched; the requester must split shapes the bus cannot carry.
  bus_config is a static pin: it passes two flops and is latched once
  after reset, so it must be settled before reset is released and a
  mode change needs a fresh reset.
  Reads return data one cycle after each beat, with no wait states;
  a stall input would have to freeze every process here.
*/
// Summary of operation
// - Only single nonsequential transfers or permitted bursts reach the bus.
// - Read bursts come only from line fills; other reads are one word.
// - Every line fill reads exactly eight words.
// - Standard mode write bursts are 2, 3, 4 or 8 words, all bytes written.
// - Enhanced mode merged write bursts are 2, 3, 4 or 8 words.
// - Line-burst flag rises on writes covering a full 32-byte block.
// - With the flag high on writes, all byte lanes are valid.
// - No burst crosses an aligned 32-byte boundary.
// - Fills are 8 words with flag; start word 0 standard, any enhanced.
// - Standard 2-word writes start at 0,1,2,4,5,6, all bytes written.
// - Standard 3-word writes start at 0,1,4,5, all bytes written.
// - Standard 4-word writes start at 0 or 4, all bytes written.
// - Enhanced 2-word writes start at 0,1,2,4,5,6, one to four bytes each.
// - Enhanced 3/4-word: end words one to four bytes, middle zero to four.
// - Eight-word writes start at word 0, flag high, all 32 bytes.
// - Enhanced single writes use the byte mask; standard ones any word.
// - Fill starts at critical word enhanced, word 0 standard.
// - Nonsequential transfer is one idle then sequential cycles.
// - Line-burst flag changes with the address outputs.
`timescale 1ns/100ps
`default_nettype none
`include "mbtg_regs.vh"

module mbtg_gen #(
  parameter ADDR_W = 32
) (
  input  wire              sys_clk,
  input  wire              rst,
  input  wire              bus_config,
  input  wire              req_valid,
  input  wire [1:0]        req_kind,
  input  wire [ADDR_W-1:0] req_addr,
  input  wire [3:0]        req_len,
  input  wire [31:0]       req_masks,
  input  wire [255:0]      req_wdata,
  output reg               req_ready,
  output reg               req_reject,
  output reg               req_done,
  output reg [255:0]       fill_data,
  output reg [ADDR_W-1:0]  mem_addr,
  output reg               mem_idle,
  output reg               mem_write,
  output reg               line_burst_flag,
  output reg [3:0]         mem_lanes,
  output reg [31:0]        mem_wdata,
  input  wire [31:0]       mem_rdata
);

  // =====================================================================
  // States
  localparam ST_IDLE = 2'h0;
  localparam ST_NSEQ = 2'h1;
  localparam ST_BEAT = 2'h2;
  localparam ST_DONE = 2'h3;

  reg  [1:0]   state;
  reg  [1:0]   next_state;
  reg          cfg;
  reg  [1:0]   kind;
  reg  [3:0]   len;
  reg  [2:0]   first;
  reg  [2:0]   step;
  reg  [3:0]   beat;
  reg  [31:0]  base;
  reg  [31:0]  masks;
  reg  [255:0] wdata;
  reg          rd_pending;
  reg  [2:0]   rd_step;
  reg          cfg_taken;
  reg          cfg_meta;
  reg          cfg_sync;
  wire         legal;
  wire [31:0]  beat_addr;
  wire         take;
  wire         req_fill;
  wire         req_wr;
  wire [2:0]   start_word;
  wire [2:0]   next_step;
  wire [2:0]   next_idx;
  wire         last_beat;

  // =====================================================================
  // Configuration pin
  // Two flops without reset: they keep sampling the static pin during
  // reset, so the second stage is settled when reset lets go.
  always @(posedge sys_clk) begin
    cfg_meta <= bus_config;
    cfg_sync <= cfg_meta;
  end

  // Configuration latched once out of reset; later pin motion is ignored
  // since changing mode mid-stream would break burst shapes.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg       <= 1'b0;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      cfg       <= cfg_sync;
      cfg_taken <= 1'b1;
    end
  end

  // =====================================================================
  // Request decode shared by the state machine and bus outputs
  // A standard-mode fill always opens at word 0 of its line
  assign take       = req_valid && req_ready && legal;
  assign req_fill   = (req_kind == `MBTG_KIND_FILL);
  assign req_wr     = (req_kind == `MBTG_KIND_WRITE);
  assign start_word = (req_fill && !cfg) ? 3'h0 : req_addr[4:2];
  // Position of the next beat; the 3-bit sum wraps inside the block
  assign next_step  = step + 3'h1;
  assign next_idx   = beat_addr[4:2];
  assign last_beat  = (beat == len - 4'h1);

  // =====================================================================
  // Shape check and beat address
  mbtg_shape_check u_check (
    .enhanced (cfg),
    .kind     (req_kind),
    .len      (req_len),
    .start    (req_addr[4:2]),
    .masks    (req_masks),
    .legal    (legal)
  );

  mbtg_beat_addr u_addr (
    .base  (base),
    .first (first),
    .step  (next_step),
    .addr  (beat_addr)
  );

  // =====================================================================
  // Lane selection
  // Lane picker for the word at a given burst position
  function [3:0] lane_of;
    input [31:0] m;
    input [2:0]  p;
    begin
      lane_of = m[4*p +: 4];
    end
  endfunction

  // Byte lanes of the next beat; reads always enable every lane
  wire [3:0]   next_lanes;
  assign next_lanes = (kind == `MBTG_KIND_WRITE) ?
                      lane_of(masks, next_step) : `MBTG_MASK_FULL;

  // =====================================================================
  // State machine
  // State register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) state <= ST_IDLE;
    else     state <= next_state;
  end

  // Next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (take) next_state = ST_NSEQ;
      ST_NSEQ: next_state = ST_BEAT;
      ST_BEAT: if (last_beat) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // =====================================================================
  // Request capture and beat sequencing
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_ready  <= 1'b0;
      req_reject <= 1'b0;
      kind       <= `MBTG_KIND_READ;
      len        <= 4'h1;
      first      <= 3'h0;
      step       <= 3'h0;
      beat       <= 4'h0;
      base       <= 32'h0000_0000;
      masks      <= 32'h0000_0000;
      wdata      <= {256{1'b0}};
    end else begin
      req_reject <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            if (!legal) begin
              req_reject <= 1'b1;
              req_ready  <= 1'b1;
            end
            kind  <= req_kind;
            len   <= req_len;
            base  <= {req_addr[ADDR_W-1:5], 5'h00};
            masks <= req_masks;
            wdata <= req_wdata;
            beat  <= 4'h0;
            step  <= 3'h0;
            // Standard fills begin at word 0, enhanced at critical word
            if (req_kind == `MBTG_KIND_FILL && !cfg)
              first <= 3'h0;
            else
              first <= req_addr[4:2];
          end
        end
        ST_NSEQ: begin
          req_ready <= 1'b0;
        end
        ST_BEAT: begin
          beat <= beat + 4'h1;
          step <= step + 3'h1;
        end
        default: req_ready <= 1'b0;
      endcase
    end
  end

  // =====================================================================
  // Bus outputs: address, flag and direction move together; when the
  // bus goes idle they keep their last values to save needless toggling
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_addr        <= {ADDR_W{1'b0}};
      mem_idle        <= 1'b1;
      mem_write       <= 1'b0;
      line_burst_flag <= 1'b0;
      mem_lanes       <= 4'h0;
      mem_wdata       <= 32'h0000_0000;
    end else begin
      mem_idle <= 1'b1;
      case (next_state)
        ST_NSEQ: begin
          // Address posted in the idle cycle ahead of the first beat
          mem_addr  <= {req_addr[ADDR_W-1:5], start_word, 2'b00};
          mem_write <= req_wr;
          line_burst_flag <= req_fill ||
                             (req_wr && req_len == 4'h8);
          mem_lanes <= req_wr ? lane_of(req_masks, 3'h0) : `MBTG_MASK_FULL;
          mem_wdata <= req_wdata[32*req_addr[4:2] +: 32];
        end
        ST_BEAT: begin
          mem_idle <= 1'b0;
          if (state == ST_BEAT) begin
            // Next beat one word up; the 3-bit index wraps inside the
            // block, so no carry can reach bit 5 and leave the block
            mem_addr  <= beat_addr;
            mem_lanes <= next_lanes;
            mem_wdata <= wdata[32*next_idx +: 32];
          end
        end
        default: begin
          // Idle: address and direction hold to save bus toggling
          line_burst_flag <= line_burst_flag;
        end
      endcase
    end
  end

  // =====================================================================
  // Read data capture: data of a beat arrives one cycle after it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_pending <= 1'b0;
      rd_step    <= 3'h0;
      fill_data  <= {256{1'b0}};
    end else begin
      rd_pending <= (state == ST_BEAT) && !mem_write;
      rd_step    <= first + step;
      if (rd_pending)
        fill_data[32*rd_step +: 32] <= mem_rdata;
    end
  end

  // Done pulse two cycles after the last beat; the last fill word lands
  // at the same edge, so fill_data is complete while the pulse stands
  always @(posedge sys_clk or posedge rst) begin
    if (rst) req_done <= 1'b0;
    else     req_done <= (state == ST_DONE);
  end

endmodule
`default_nettype wire

// ### testbench/mbtg_mem_model.sv
/*
  Memory side model: answers read beats one cycle later.
  Assumes the generator never inserts wait states.
*/
`timescale 1ns/100ps
`default_nettype none
module mbtg_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_idle,
  input  wire logic        mem_write,
  output logic      [31:0] mem_rdata
);
  // =====================================================================
  // Read data
  // Data is the inverted beat address; off-beat the bus toggles so a
  // stale word is never mistaken for a fresh one
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= 32'h0000_0000;
    end else if (!mem_idle && !mem_write) begin
      mem_rdata <= ~mem_addr;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ### testbench/mbtg_gen_properties.sv
/*
  Bus shape checker for the generator.
  Assumes bus_config stays static outside reset.
*/
`timescale 1ns/100ps
`default_nettype none
module mbtg_gen_properties #(
  parameter ADDR_W = 32
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              bus_config,
  input  wire logic              req_ready,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_idle,
  input  wire logic              mem_write,
  input  wire logic              line_burst_flag,
  input  wire logic [3:0]        mem_lanes
);
  // =====================================================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_step;
    !mem_idle && $past(!mem_idle) |-> mem_addr[31:5] ==
      $past(mem_addr[31:5]) && mem_addr[4:2] == 3'($past(mem_addr[4:2]) + 1);
  endproperty
  a_step: assert property (p_step) else $error("beat address step");
  property p_dir;
    !mem_idle && $past(!mem_idle) |-> $stable(mem_write)
      && $stable(line_burst_flag);
  endproperty
  a_dir: assert property (p_dir) else $error("direction changed");
  property p_lanes;
    line_burst_flag && mem_write && !mem_idle |-> mem_lanes == 4'hf;
  endproperty
  a_lanes: assert property (p_lanes) else $error("partial lanes");
  property p_nonseq;
    $fell(mem_idle) |-> $past(req_ready, 2) && !$past(req_ready);
  endproperty
  a_nonseq: assert property (p_nonseq) else $error("no idle lead");
  property p_flag8;
    $fell(mem_idle) && line_burst_flag |-> (!mem_idle) [*8] ##1 mem_idle;
  endproperty
  a_flag8: assert property (p_flag8) else $error("flag burst length");
  property p_wstart;
    $fell(mem_idle) && line_burst_flag && mem_write |-> mem_addr[4:2] == 0;
  endproperty
  a_wstart: assert property (p_wstart) else $error("full write start");
  property p_sfill;
    $fell(mem_idle) && !mem_write && line_burst_flag && !bus_config
      |-> mem_addr[4:2] == 0;
  endproperty
  a_sfill: assert property (p_sfill) else $error("standard fill start");
  property p_rsingle;
    $fell(mem_idle) && !mem_write && !line_burst_flag |=> mem_idle;
  endproperty
  a_rsingle: assert property (p_rsingle) else $error("read burst");
  property p_slanes;
    !bus_config && mem_write && !mem_idle && $past(!mem_idle)
      |-> mem_lanes == 4'hf;
  endproperty
  a_slanes: assert property (p_slanes) else $error("standard lanes");
endmodule
bind mbtg_gen mbtg_gen_properties #(.ADDR_W(ADDR_W)) i_mbtg_gen_properties (
  .sys_clk(sys_clk), .rst(rst), .bus_config(bus_config),
  .req_ready(req_ready), .mem_addr(mem_addr),
  .mem_idle(mem_idle), .mem_write(mem_write),
  .line_burst_flag(line_burst_flag), .mem_lanes(mem_lanes));
`default_nettype wire

// ### testbench/test_memory_bus_transaction_gen.sv
/*
  Self-checking bench: fills, writes and refusals in both modes.
  Assumes the memory model and checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mbtg_regs.vh"
module test_memory_bus_transaction_gen;
  logic         sys_clk    = 1'b0;
  logic         rst        = 1'b1;
  logic         bus_config = 1'b0;
  logic         req_valid  = 1'b0;
  logic [1:0]   req_kind   = 2'h0;
  logic [31:0]  req_addr   = 32'h0000_0000;
  logic [3:0]   req_len    = 4'h1;
  logic [31:0]  req_masks  = 32'h0000_0000;
  logic [255:0] req_wdata;
  logic [255:0] fill_data;
  logic [31:0]  mem_addr, mem_wdata, mem_rdata, first;
  logic [3:0]   mem_lanes;
  logic [1:0]   shape;
  logic         req_ready, req_reject, req_done;
  logic         mem_idle, mem_write, line_burst_flag;
  int           fails = 0, check_count = 0, cycles = 0, beats, bad, rej;
  mbtg_gen #(.ADDR_W(32)) i_mbtg_gen (.sys_clk(sys_clk), .rst(rst),
    .bus_config(bus_config), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_len(req_len), .req_masks(req_masks),
    .req_wdata(req_wdata), .req_ready(req_ready), .req_reject(req_reject),
    .req_done(req_done), .fill_data(fill_data), .mem_addr(mem_addr),
    .mem_idle(mem_idle), .mem_write(mem_write), .mem_lanes(mem_lanes),
    .line_burst_flag(line_burst_flag), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  mbtg_mem_model i_mbtg_mem_model (.sys_clk(sys_clk), .rst(rst),
    .mem_addr(mem_addr), .mem_idle(mem_idle), .mem_write(mem_write),
    .mem_rdata(mem_rdata));
  // =====================================================================
  // Clock and hang guard; a run needs well under 1000 cycles
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish;
    end
  end
  // =====================================================================
  // Shared tasks
  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Config is latched once after reset, so mode changes need a reset
  task reset_to(input logic c);
    rst <= 1'b1;
    bus_config <= c;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Offer one request, then log beats until done or refused
  task run(input logic [1:0] k, input logic [31:0] a, input logic [3:0] n,
           input logic [31:0] m);
    int p;
    beats = 0;
    bad = 0;
    rej = 0;
    first = 32'h0000_0000;
    shape = 2'h0;
    req_kind <= k;
    req_addr <= a;
    req_len <= n;
    req_masks <= m;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    while (req_ready !== 1'b1) @(posedge sys_clk);
    req_valid <= 1'b0;
    for (p = 0; p < 40 && req_done !== 1'b1 && rej == 0; p++) begin
      @(posedge sys_clk);
      rej = (req_reject === 1'b1);
      if (mem_idle === 1'b0) begin
        if (beats == 0) begin
          first = mem_addr;
          shape = {mem_write, line_burst_flag};
        end
        if (mem_write && (mem_lanes !== m[4*beats+:4] ||
            mem_wdata !== req_wdata[32*mem_addr[4:2]+:32])) bad++;
        beats++;
      end
    end
    @(posedge sys_clk);
  endtask
  // =====================================================================
  // Scenarios
  task fill_case(input logic [31:0] a);
    int i;
    run(`MBTG_KIND_FILL, a, 4'h8, 32'h0000_0000);
    chk(beats, 8);
    chk(first, a);
    chk(shape, 2'h1);
    for (i = 0; i < 8; i++) begin
      chk(fill_data[32*i+:32], ~{a[31:5], i[2:0], 2'b00});
    end
    $display("fill at %h done", a);
  endtask
  task write_case(input logic [31:0] a, input logic [3:0] n,
                  input logic [31:0] m);
    run(`MBTG_KIND_WRITE, a, n, m);
    chk(beats, n);
    chk(first, a);
    chk(shape, {1'b1, n == 4'h8});
    chk(bad, 0);
    $display("write of %0d at %h done", n, a);
  endtask
  task reject_case(input logic [1:0] k, input logic [31:0] a,
                   input logic [3:0] n, input logic [31:0] m);
    run(k, a, n, m);
    chk(rej, 1);
    chk(beats, 0);
    $display("refusal at %h done", a);
  endtask
  task read_case;
    run(`MBTG_KIND_READ, 32'h0000_0234, 4'h1, 32'h0000_0000);
    chk(beats, 1);
    chk(first, 32'h0000_0234);
    chk(shape, 2'h0);
    $display("single read done");
  endtask
  // =====================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      req_wdata[32*i+:32] = 32'h1357_0000 + i * 32'h0101_0101;
    end
    reset_to(`MBTG_CFG_STANDARD);
    fill_case(32'h0000_1000);
    read_case;
    write_case(32'h0000_2000, 4'h8, 32'hffff_ffff);
    write_case(32'h0000_2010, 4'h4, 32'h0000_ffff);
    write_case(32'h0000_2014, 4'h3, 32'h0000_0fff);
    write_case(32'h0000_2018, 4'h2, 32'h0000_00ff);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_200c, 4'h2, 32'h0000_00ff);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_2008, 4'h4, 32'h0000_ffff);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_2004, 4'h8, 32'hffff_ffff);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_2000, 4'h2, 32'h0000_007f);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_2000, 4'h5, 32'h000f_ffff);
    reject_case(`MBTG_KIND_READ, 32'h0000_2000, 4'h2, 32'h0000_0000);
    reject_case(`MBTG_KIND_FILL, 32'h0000_2000, 4'h4, 32'h0000_0000);
    reject_case(`MBTG_KIND_FILL, 32'h0000_2008, 4'h8, 32'h0000_0000);
    reset_to(`MBTG_CFG_ENHANCED);
    fill_case(32'h0000_3018);
    write_case(32'h0000_3014, 4'h3, 32'h0000_0f01);
    write_case(32'h0000_3008, 4'h1, 32'h0000_0003);
    write_case(32'h0000_300c, 4'h1, 32'h0000_0008);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_3010, 4'h3, 32'h0000_00f1);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_3000, 4'h2, 32'h0000_0010);
    reject_case(`MBTG_KIND_WRITE, 32'h0000_3008, 4'h3, 32'h0000_0fff);
    tally_and_finish;
  end
endmodule
`default_nettype wire
